// file: src/rqc_boost_preset_field_ctrl.sv
// receive equalizer control: per-channel settings, readback and address pins
`timescale 1ns/1ps
`default_nettype none
module rqc_boost_preset_field_ctrl
   import rqc_pkg::*;
#(
   parameter int         NUM_CH     = RQC_NUM_CH,
   parameter logic [4:0] SLAVE_BASE = RQC_SLAVE_BASE
) (
   // clock and resets
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic                          reset_input_low,
   // address-select pins
   input  wire logic                          slave_addr_pin_low,
   input  wire logic                          slave_addr_pin_high,
   // register port from the serial front end
   input  wire logic                          wr_en,
   input  wire logic                          rd_en,
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [7:0]                    wr_data,
   output var  logic [7:0]                    rd_data_r,
   output var  logic                          rd_valid_r,
   output var  logic                          rd_hit_r,
   // serial slave address
   output var  logic [6:0]                    slave_addr_r,
   // receive data path
   input  wire logic [NUM_CH-1:0]             rx_data,
   output var  logic [NUM_CH-1:0]             rx_data_r,
   // per-channel settings to the analog equalizer
   output var  logic [NUM_CH-1:0]             pn_swap_r,
   output var  logic [NUM_CH-1:0]             rx_en_r,
   output var  logic [NUM_CH-1:0]             adv_mode_r,
   output var  logic [NUM_CH-1:0]             bypass_active_r,
   output var  logic [NUM_CH-1:0]             board_group_r,
   output var  logic [NUM_CH-1:0][2:0]        preset_r,
   output var  logic [NUM_CH-1:0][5:0]        mid_level_r,
   output var  logic [NUM_CH-1:0][5:0]        high_level_r
);

   if (NUM_CH < 1 || NUM_CH > RQC_NUM_CH) begin : g_bad_ch
      $error("NUM_CH must lie between 1 and 8");
   end

   // the decode below hard-wires these field positions
   if (RQC_BOOST_W != 6 || RQC_BOOST_SIGN_POS != RQC_BOOST_W - 1) begin : g_bad_boost
      $error("boost field must be six bits with its sign on top");
   end

   if (RQC_EQ1_SRC_POS < RQC_BOOST_W || RQC_EQ1_SRC_POS > 7) begin : g_bad_src
      $error("control-source bit must sit above the boost field");
   end

   if (RQC_CH_POS + 3 != 6) begin : g_bad_map
      $error("channel field must sit just below the window bits");
   end

   if (RQC_PRESET_W != 3 || RQC_CFG_PRESET_LSB + RQC_PRESET_W > RQC_CFG_EN_POS) begin : g_bad_pre
      $error("preset field must be three bits below the enable bit");
   end

   if (RQC_GRP_OVR_POS == RQC_GRP_CHOICE_POS) begin : g_bad_grp
      $error("group override and choice bits must differ");
   end

   if (RQC_CFG_PN_POS == RQC_CFG_BYP_POS || RQC_CFG_PN_POS == RQC_CFG_EN_POS
       || RQC_CFG_BYP_POS == RQC_CFG_EN_POS) begin : g_bad_cfg
      $error("configuration bits must not share a position");
   end

   // address decode: window, channel and register offset
   function automatic logic addr_hit(input logic [7:0] a);
      logic [2:0] ch;
      ch = a[RQC_CH_POS+2:RQC_CH_POS];
      addr_hit = (a[7:6] == RQC_CH_WIN) && (32'(ch) < NUM_CH);
   endfunction : addr_hit

   function automatic logic [2:0] addr_ch(input logic [7:0] a);
      addr_ch = a[RQC_CH_POS+2:RQC_CH_POS];
   endfunction : addr_ch

   // storage
   logic                   clr;
   logic [NUM_CH-1:0]      ch_wr;
   logic [NUM_CH-1:0][7:0] cfg_q;
   logic [NUM_CH-1:0][7:0] eq1_q;
   logic [NUM_CH-1:0][7:0] eq3_q;
   logic [NUM_CH-1:0][7:0] grp_q;

   // pin reset is synchronous to clk; it clears but never resets the flops asynchronously
   assign clr = ~reset_input_low;

   // unmapped writes light no enable, so they are dropped
   always_comb begin
      ch_wr = '0;
      if (wr_en && addr_hit(reg_addr)) begin
         ch_wr[addr_ch(reg_addr)] = 1'b1;
      end
   end

   // all channels share offset and data lines; only the write enable differs
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      rqc_chan_regs u_regs (
         .clk     (clk),
         .rst     (rst),
         .clr     (clr),
         .wr_en   (ch_wr[i]),
         .wr_sel  (reg_addr[2:0]),
         .wr_data (wr_data),
         .cfg_r   (cfg_q[i]),
         .eq1_r   (eq1_q[i]),
         .eq3_r   (eq3_q[i]),
         .grp_r   (grp_q[i])
      );
   end

   // register word at an offset inside one channel; gaps read as zero
   function automatic logic [7:0] reg_word(input logic [2:0] ofs, input logic [7:0] c,
                                           input logic [7:0] e1, input logic [7:0] e3,
                                           input logic [7:0] g);
      case (ofs)
         RQC_OFS_CFG: reg_word = c;
         RQC_OFS_EQ1: reg_word = e1;
         RQC_OFS_EQ3: reg_word = e3;
         RQC_OFS_GRP: reg_word = g;
         default:     reg_word = 8'h00;
      endcase
   endfunction : reg_word

   // readback
   logic [7:0] rd_data_nxt;
   logic       rd_valid_nxt;
   logic       rd_hit_nxt;

   always_comb begin
      rd_data_nxt  = 8'h00;
      rd_valid_nxt = rd_en;
      rd_hit_nxt   = 1'b0;
      if (rd_en && addr_hit(reg_addr)) begin
         rd_hit_nxt  = 1'b1;
         // gaps inside a channel still count as a hit but read zero
         rd_data_nxt = reg_word(reg_addr[2:0], cfg_q[addr_ch(reg_addr)],
                                eq1_q[addr_ch(reg_addr)], eq3_q[addr_ch(reg_addr)],
                                grp_q[addr_ch(reg_addr)]);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data_r  <= 8'h00;
         rd_valid_r <= 1'b0;
         rd_hit_r   <= 1'b0;
      end else begin
         rd_data_r  <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
         rd_hit_r   <= rd_hit_nxt;
      end
   end

   // slave address follows the pins; they may be re-strapped at any time
   logic [6:0] slave_addr_nxt;

   always_comb begin
      slave_addr_nxt = {SLAVE_BASE, slave_addr_pin_high, slave_addr_pin_low};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slave_addr_r <= {SLAVE_BASE, 2'h0};
      end else begin
         slave_addr_r <= slave_addr_nxt;
      end
   end

   // field decode shared by the groups below
   function automatic logic is_adv(input logic [7:0] eq1);
      is_adv = eq1[RQC_EQ1_SRC_POS];
   endfunction : is_adv

   function automatic logic [5:0] boost_fld(input logic [7:0] r);
      boost_fld = r[RQC_BOOST_W-1:0];
   endfunction : boost_fld

   // data path; inversion acts on data as it arrives, one register stage late
   logic [NUM_CH-1:0] rx_data_nxt;

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         rx_data_nxt[i] = rx_data[i] ^ cfg_q[i][RQC_CFG_PN_POS];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_data_r <= '0;
      end else begin
         rx_data_r <= rx_data_nxt;
      end
   end

   // plain per-channel state bits
   logic [NUM_CH-1:0] pn_swap_nxt;
   logic [NUM_CH-1:0] rx_en_nxt;
   logic [NUM_CH-1:0] adv_mode_nxt;

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         pn_swap_nxt[i]  = cfg_q[i][RQC_CFG_PN_POS];
         rx_en_nxt[i]    = cfg_q[i][RQC_CFG_EN_POS];
         adv_mode_nxt[i] = is_adv(eq1_q[i]);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pn_swap_r  <= {NUM_CH{RQC_CFG_RST[RQC_CFG_PN_POS]}};
         rx_en_r    <= {NUM_CH{RQC_CFG_RST[RQC_CFG_EN_POS]}};
         adv_mode_r <= {NUM_CH{RQC_EQ1_RST[RQC_EQ1_SRC_POS]}};
      end else begin
         pn_swap_r  <= pn_swap_nxt;
         rx_en_r    <= rx_en_nxt;
         adv_mode_r <= adv_mode_nxt;
      end
   end

   // basic mode: bypass, group and preset, all held quiet in advanced mode
   logic [NUM_CH-1:0]      bypass_active_nxt;
   logic [NUM_CH-1:0]      board_group_nxt;
   logic [NUM_CH-1:0][2:0] preset_nxt;

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         if (is_adv(eq1_q[i])) begin
            // basic fields stay stored; outputs show the direct boosts only
            bypass_active_nxt[i] = 1'b0;
            board_group_nxt[i]   = 1'b1;
            preset_nxt[i]        = 3'h0;
         end else begin
            bypass_active_nxt[i] = cfg_q[i][RQC_CFG_BYP_POS];
            board_group_nxt[i] = rqc_board_group(grp_q[i][RQC_GRP_OVR_POS],
                                                 grp_q[i][RQC_GRP_CHOICE_POS]);
            if (bypass_active_nxt[i]) begin
               // fixed 1.5 dB boost; the preset code is not passed on
               preset_nxt[i] = 3'h0;
            end else begin
               preset_nxt[i] = cfg_q[i][RQC_CFG_PRESET_LSB +: RQC_PRESET_W];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bypass_active_r <= {NUM_CH{RQC_CFG_RST[RQC_CFG_BYP_POS]}};
         board_group_r   <= '1;
         preset_r        <= '0;
      end else begin
         bypass_active_r <= bypass_active_nxt;
         board_group_r   <= board_group_nxt;
         preset_r        <= preset_nxt;
      end
   end

   // advanced mode: signed direct boosts, zero while basic mode acts
   logic [NUM_CH-1:0][5:0] mid_level_nxt;
   logic [NUM_CH-1:0][5:0] high_level_nxt;

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         mid_level_nxt[i]  = 6'h00;
         high_level_nxt[i] = 6'h00;
         if (is_adv(eq1_q[i])) begin
            mid_level_nxt[i]  = rqc_boost_level(boost_fld(eq1_q[i]));
            high_level_nxt[i] = rqc_boost_level(boost_fld(eq3_q[i]));
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mid_level_r  <= '0;
         high_level_r <= '0;
      end else begin
         mid_level_r  <= mid_level_nxt;
         high_level_r <= high_level_nxt;
      end
   end

endmodule : rqc_boost_preset_field_ctrl
`default_nettype wire

// file: include/rqc_pkg.sv
// constants, field layout and helpers for the receive equalizer control block
package rqc_pkg;

   // channel count served by the three-bit channel field of the address
   localparam int RQC_NUM_CH = 8;

   // register byte addresses: channel n sits at base + n * stride
   localparam logic [1:0] RQC_CH_WIN      = 2'h2;
   localparam int         RQC_CH_POS      = 3;
   localparam logic [2:0] RQC_OFS_CFG     = 3'h0;
   localparam logic [2:0] RQC_OFS_EQ1     = 3'h3;
   localparam logic [2:0] RQC_OFS_EQ3     = 3'h4;
   localparam logic [2:0] RQC_OFS_GRP     = 3'h5;

   // configuration register fields
   localparam int RQC_CFG_PN_POS     = 6;
   localparam int RQC_CFG_BYP_POS    = 5;
   localparam int RQC_CFG_EN_POS     = 4;
   localparam int RQC_CFG_PRESET_LSB = 0;
   localparam int RQC_PRESET_W       = 3;

   // mid-band / high-band boost register fields
   localparam int RQC_EQ1_SRC_POS    = 6;
   localparam int RQC_BOOST_W        = 6;
   localparam int RQC_BOOST_SIGN_POS = 5;

   // group register fields
   localparam int RQC_GRP_OVR_POS    = 1;
   localparam int RQC_GRP_CHOICE_POS = 0;

   // reset values
   localparam logic [7:0] RQC_CFG_RST = 8'h30;
   localparam logic [7:0] RQC_EQ1_RST = 8'h00;
   localparam logic [7:0] RQC_EQ3_RST = 8'h00;
   localparam logic [7:0] RQC_GRP_RST = 8'h00;

   // writable bits; all others are reserved and read as zero
   localparam logic [7:0] RQC_CFG_MASK = 8'h77;
   localparam logic [7:0] RQC_EQ1_MASK = 8'h7F;
   localparam logic [7:0] RQC_EQ3_MASK = 8'h3F;
   localparam logic [7:0] RQC_GRP_MASK = 8'h03;

   // upper five bits of the serial slave address (value is arbitrary)
   localparam logic [4:0] RQC_SLAVE_BASE = 5'h12;

   // sign-magnitude boost field to a signed level around mid boost
   function automatic logic signed [5:0] rqc_boost_level(input logic [5:0] fld);
      logic [5:0] mag;
      mag = {1'b0, fld[4:0]};
      if (fld[RQC_BOOST_SIGN_POS]) begin
         rqc_boost_level = mag;
      end else begin
         rqc_boost_level = -mag;
      end
   endfunction : rqc_boost_level

   // board-trace group unless the override asks for the choice bit
   function automatic logic rqc_board_group(input logic ovr, input logic choice);
      rqc_board_group = ovr ? choice : 1'b1;
   endfunction : rqc_board_group

endpackage : rqc_pkg

// file: src/rqc_chan_regs.sv
// one receive channel's four control registers
`timescale 1ns/1ps
`default_nettype none
module rqc_chan_regs
   import rqc_pkg::*;
(
   // clock and resets
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       clr,
   // write port
   input  wire logic       wr_en,
   input  wire logic [2:0] wr_sel,
   input  wire logic [7:0] wr_data,
   // stored values
   output var  logic [7:0] cfg_r,
   output var  logic [7:0] eq1_r,
   output var  logic [7:0] eq3_r,
   output var  logic [7:0] grp_r
);

   logic [7:0] cfg_nxt;
   logic [7:0] eq1_nxt;
   logic [7:0] eq3_nxt;
   logic [7:0] grp_nxt;

   always_comb begin
      cfg_nxt = cfg_r;
      eq1_nxt = eq1_r;
      eq3_nxt = eq3_r;
      grp_nxt = grp_r;
      if (clr) begin
         cfg_nxt = RQC_CFG_RST;
         eq1_nxt = RQC_EQ1_RST;
         eq3_nxt = RQC_EQ3_RST;
         grp_nxt = RQC_GRP_RST;
      end else if (wr_en) begin
         case (wr_sel)
            RQC_OFS_CFG: cfg_nxt = wr_data & RQC_CFG_MASK;
            RQC_OFS_EQ1: eq1_nxt = wr_data & RQC_EQ1_MASK;
            RQC_OFS_EQ3: eq3_nxt = wr_data & RQC_EQ3_MASK;
            RQC_OFS_GRP: grp_nxt = wr_data & RQC_GRP_MASK;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_r <= RQC_CFG_RST;
         eq1_r <= RQC_EQ1_RST;
         eq3_r <= RQC_EQ3_RST;
         grp_r <= RQC_GRP_RST;
      end else begin
         cfg_r <= cfg_nxt;
         eq1_r <= eq1_nxt;
         eq3_r <= eq3_nxt;
         grp_r <= grp_nxt;
      end
   end

endmodule : rqc_chan_regs
`default_nettype wire

// file: verification/rqc_boost_preset_field_ctrl_chk.sv
// port assertions for the receive equalizer control block
`timescale 1ns/1ps
`default_nettype none
module rqc_boost_preset_field_ctrl_chk
   import rqc_pkg::*;
#(
   parameter int         NUM_CH     = RQC_NUM_CH,
   parameter logic [4:0] SLAVE_BASE = RQC_SLAVE_BASE
) (
   // clock and resets
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic                   reset_input_low,
   // pins and read port
   input wire logic                   slave_addr_pin_low,
   input wire logic                   slave_addr_pin_high,
   input wire logic [6:0]             slave_addr_r,
   input wire logic                   rd_en,
   input wire logic [7:0]             rd_data_r,
   input wire logic                   rd_valid_r,
   input wire logic                   rd_hit_r,
   // data path and settings
   input wire logic [NUM_CH-1:0]      rx_data,
   input wire logic [NUM_CH-1:0]      rx_data_r,
   input wire logic [NUM_CH-1:0]      pn_swap_r,
   input wire logic [NUM_CH-1:0]      adv_mode_r,
   input wire logic [NUM_CH-1:0]      bypass_active_r,
   input wire logic [NUM_CH-1:0]      board_group_r,
   input wire logic [NUM_CH-1:0][2:0] preset_r,
   input wire logic [NUM_CH-1:0][5:0] mid_level_r,
   input wire logic [NUM_CH-1:0][5:0] high_level_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_addr_pins: assert property (
      slave_addr_r == {SLAVE_BASE, $past(slave_addr_pin_high), $past(slave_addr_pin_low)})
      else $error("slave address does not follow the pins");
   // data and swap output are registered at one edge from the same swap bit
   a_pol_path: assert property (
      rx_data_r == ($past(rx_data) ^ pn_swap_r))
      else $error("receive data polarity wrong");
   a_read_pulse: assert property (rd_valid_r == $past(rd_en))
      else $error("read valid not one cycle after strobe");
   a_idle_data: assert property (!rd_valid_r |-> rd_data_r == 8'h00)
      else $error("read data not zero while idle");
   a_miss_zero: assert property (rd_valid_r && !rd_hit_r |-> rd_data_r == 8'h00)
      else $error("unmapped read returned data");
   a_soft_rst: assert property (!reset_input_low ##1 !reset_input_low |=>
      adv_mode_r == '0 && pn_swap_r == '0 && bypass_active_r == '1 && board_group_r == '1
      && preset_r == '0 && mid_level_r == '0)
      else $error("settings not at defaults under reset pin");
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      a_force_preset: assert property (
         bypass_active_r[i] || adv_mode_r[i] |-> preset_r[i] == 3'h0)
         else $error("preset acts under bypass or advanced mode");
      a_adv_excl: assert property (
         adv_mode_r[i] |-> !bypass_active_r[i] && board_group_r[i])
         else $error("basic controls act in advanced mode");
      a_basic_lvl: assert property (!adv_mode_r[i] |-> mid_level_r[i] == 6'h00)
         else $error("direct boost acts in basic mode");
      a_basic_high: assert property (!adv_mode_r[i] |-> high_level_r[i] == 6'h00)
         else $error("direct high boost acts in basic mode");
   end
   c_read_hit: cover property (rd_valid_r && rd_hit_r);
   c_adv_mode: cover property (adv_mode_r != '0);
   c_soft_rst: cover property (!reset_input_low ##1 reset_input_low);
endmodule : rqc_boost_preset_field_ctrl_chk
`default_nettype wire

// file: verification/rqc_host_model.sv
// host controller model driving the register port one byte at a time
`timescale 1ns/1ps
`default_nettype none
module rqc_host_model (
   // clock
   input wire logic       clk,
   // register port
   output var logic       wr_en,
   output var logic       rd_en,
   output var logic [7:0] reg_addr,
   output var logic [7:0] wr_data,
   input wire logic [7:0] rd_data_r,
   input wire logic       rd_hit_r
);
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      reg_addr = 8'h00;
      wr_data = 8'h00;
   end
   // released lines show the inverse so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      wr_en = 1'b1;
      reg_addr = a;
      wr_data = d;
      @(posedge clk);
      #1;
      wr_en = 1'b0;
      reg_addr = ~a;
      wr_data = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(posedge clk);
      #1;
      rd_en = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1;
      rd_en = 1'b0;
      reg_addr = ~a;
      d = rd_data_r;
      h = rd_hit_r;
   endtask : rd
endmodule : rqc_host_model
`default_nettype wire

// file: verification/rqc_boost_preset_field_ctrl_test.sv
// self-checking bench for the receive equalizer control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module rqc_boost_preset_field_ctrl_test;
   import rqc_pkg::*;
   logic             clk = 1'b0, rst = 1'b1, reset_input_low = 1'b1;
   logic             slave_addr_pin_low = 1'b0, slave_addr_pin_high = 1'b0;
   logic             wr_en, rd_en, rd_valid_r, rd_hit_r;
   logic [7:0]       reg_addr, wr_data, rd_data_r, v;
   logic [6:0]       slave_addr_r;
   logic [7:0]       rx_data = 8'h00, rx_data_r, pn_swap_r, rx_en_r, adv_mode_r;
   logic [7:0]       bypass_active_r, board_group_r;
   logic [7:0][2:0]  preset_r;
   logic [7:0][5:0]  mid_level_r, high_level_r;
   logic [7:0]       sh[8][4];
   logic [2:0]       ofs[4] = '{RQC_OFS_CFG, RQC_OFS_EQ1, RQC_OFS_EQ3, RQC_OFS_GRP};
   logic [7:0]       msk[4] = '{RQC_CFG_MASK, RQC_EQ1_MASK, RQC_EQ3_MASK, RQC_GRP_MASK};
   logic [7:0]       corner[4] = '{8'h40, 8'h7F, 8'h60, 8'h5F};
   int               seed = 89268, err_total = 0, n_tests = 0, cyc = 0, ch;

   rqc_boost_preset_field_ctrl u_rqc_boost_preset_field_ctrl (.clk, .rst, .reset_input_low, .slave_addr_pin_low,
      .slave_addr_pin_high, .wr_en, .rd_en, .reg_addr, .wr_data, .rd_data_r, .rd_valid_r,
      .rd_hit_r, .slave_addr_r, .rx_data, .rx_data_r, .pn_swap_r, .rx_en_r, .adv_mode_r,
      .bypass_active_r, .board_group_r, .preset_r, .mid_level_r, .high_level_r);
   rqc_host_model u_rqc_host_model (.clk, .wr_en, .rd_en, .reg_addr, .wr_data,
      .rd_data_r, .rd_hit_r);

   always #25 clk = ~clk;

   function automatic logic [7:0] ra(input int c, input logic [2:0] o);
      ra = {RQC_CH_WIN, c[2:0], o};
   endfunction : ra
   // sign set adds boost, sign clear cuts it
   function automatic logic [5:0] lvl(input logic [5:0] f);
      lvl = f[5] ? {1'b0, f[4:0]} : 6'h00 - {1'b0, f[4:0]};
   endfunction : lvl
   task automatic init_sh();
      for (int i = 0; i < 8; i++) begin
         sh[i] = '{RQC_CFG_RST, RQC_EQ1_RST, RQC_EQ3_RST, RQC_GRP_RST};
      end
   endtask : init_sh
   task automatic chk_all();
      logic [7:0] c, e1, e3, g;
      logic       a;
      for (int i = 0; i < 8; i++) begin
         c = sh[i][0];
         e1 = sh[i][1];
         e3 = sh[i][2];
         g = sh[i][3];
         a = e1[6];
         `CHK(adv_mode_r[i], a)
         `CHK(pn_swap_r[i], c[6])
         `CHK(rx_en_r[i], c[4])
         `CHK(bypass_active_r[i], c[5] & ~a)
         `CHK(board_group_r[i], a | (g[1] ? g[0] : 1'b1))
         `CHK(preset_r[i], (c[5] | a) ? 3'h0 : c[2:0])
         `CHK(mid_level_r[i], a ? lvl(e1[5:0]) : 6'h00)
         `CHK(high_level_r[i], a ? lvl(e3[5:0]) : 6'h00)
      end
   endtask : chk_all
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic h);
      logic [7:0] d;
      logic       hit;
      u_rqc_host_model.rd(a, d, hit);
      `CHK(d, e)
      `CHK(hit, h)
   endtask : rd_chk
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         results();
      end
   end

   initial begin
      init_sh();
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      chk_all();
      for (int i = 0; i < 8; i++) begin
         for (int j = 0; j < 4; j++) rd_chk(ra(i, ofs[j]), sh[i][j], 1'b1);
      end
      rd_chk(ra(3, 3'h1), 8'h00, 1'b1);
      rd_chk(8'h40, 8'h00, 1'b0);
      u_rqc_host_model.wr(8'h7B, 8'h7F);
      rd_chk(ra(7, RQC_OFS_EQ1), RQC_EQ1_RST, 1'b1);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         #1;
         slave_addr_pin_low = k[0];
         slave_addr_pin_high = k[1];
         @(posedge clk);
         #1;
         `CHK(slave_addr_r, {RQC_SLAVE_BASE, k[1:0]})
      end
      // first eight passes walk every preset code in basic mode
      for (int n = 0; n < 60; n++) begin
         ch = $random(seed) & 7;
         for (int j = 0; j < 4; j++) begin
            v = 8'($random(seed));
            if (n < 8) v = (j == 0) ? (8'h10 | n[7:0]) : 8'h00;
            else if (n < 12 && j == 1) v = corner[n-8];
            u_rqc_host_model.wr(ra(ch, ofs[j]), v);
            sh[ch][j] = v & msk[j];
         end
         @(posedge clk);
         #1;
         rx_data = 8'($random(seed));
         @(posedge clk);
         #1;
         chk_all();
         for (int i = 0; i < 8; i++) `CHK(rx_data_r[i], rx_data[i] ^ sh[i][0][6])
         rd_chk(ra(ch, ofs[n%4]), sh[ch][n%4], 1'b1);
      end
      @(posedge clk);
      #1;
      reset_input_low = 1'b0;
      u_rqc_host_model.wr(ra(0, RQC_OFS_CFG), 8'hFF);
      reset_input_low = 1'b1;
      init_sh();
      @(posedge clk);
      #1;
      chk_all();
      rd_chk(ra(0, RQC_OFS_CFG), RQC_CFG_RST, 1'b1);
      results();
   end
endmodule : rqc_boost_preset_field_ctrl_test

bind rqc_boost_preset_field_ctrl rqc_boost_preset_field_ctrl_chk #(.NUM_CH(NUM_CH), .SLAVE_BASE(SLAVE_BASE))
   u_rqc_boost_preset_field_ctrl_chk (.clk, .rst, .reset_input_low, .slave_addr_pin_low,
   .slave_addr_pin_high, .slave_addr_r, .rd_en, .rd_data_r, .rd_valid_r, .rd_hit_r,
   .rx_data, .rx_data_r, .pn_swap_r, .adv_mode_r, .bypass_active_r, .board_group_r,
   .preset_r, .mid_level_r, .high_level_r);
`default_nettype wire
